// ### shared/input_cmd_cfg.svh
/*
 configuration macros for the input command interpreter: input indices, register offsets,
 field positions, reset values and timing counts.
 assumes it is included by its bare name; guarded against double inclusion.
*/
`ifndef INPUT_CMD_CFG_SVH
`define INPUT_CMD_CFG_SVH
`define N_IN            12
`define IN_MB_CLOSE     0
`define IN_MB_OPEN      1
`define IN_MB_EXT       2
`define IN_MB_SYNC      3
`define IN_FLT_RST      4
`define IN_FLT_ACK      5
`define IN_TST_UNL      6
`define IN_TST_LD       7
`define IN_TST_LVL      8
`define IN_RRUN         9
`define IN_MSTART       10
`define IN_MSTOP        11
`define ADR_CTRL        8'h00
`define ADR_POL         8'h04
`define ADR_TDUR        8'h08
`define ADR_STAT        8'h0C
`define ADR_DLY0        8'h40
`define CTRL_TLOAD_BIT  8
`define CTRL_OPEN_BIT   9
`define POL_RST         12'h000
`define TDUR_RST        16'h0000
`define DLY_RST         8'h00
`define CLK_PERIOD_NS   4
`define TICK_PERIOD_NS  1000000
`endif

// ### shared/input_cmd_pkg.sv
/*
 types for the input command interpreter: mode encoding, bus request carrier and the state record.
 assumes input_cmd_cfg.svh supplies the input count.
*/
`include "input_cmd_cfg.svh"
package input_cmd_pkg;
    typedef enum logic [2:0] {
        MODE_IDLE_CLEAR, MODE_HAND, MODE_UNATTENDED, MODE_TEST, MODE_REMOTE_RUN
    } mode_t;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } wb_req_t;

    typedef struct packed {
        mode_t                       mode;
        logic [`N_IN-1:0]            s1;
        logic [`N_IN-1:0]            s2;
        logic [`N_IN-1:0]            prev;
        logic [`N_IN-1:0]            pol;
        logic [`N_IN-1:0][7:0]       dly;
        logic [7:0]                  dcnt;
        logic                        rr;
        logic [15:0]                 tdur;
        logic [15:0]                 tcnt;
        logic                        tload_en;
        logic                        open_asg;
        logic                        tst_run;
        logic                        tst_load;
        logic                        tst_src;
        logic                        test_load_out;
        logic [17:0]                 pcnt;
        logic                        tick;
        logic                        start;
        logic                        mb_close;
        logic                        mb_open;
        logic                        mb_ext;
        logic                        sync;
        logic                        frst;
        logic                        fack;
        logic                        stop;
        logic                        ack;
        logic [31:0]                 rdat;
    } state_t;
endpackage : input_cmd_pkg

// ### core/input_cmd.sv
/*
 command interpreter for programmable digital inputs of a generator-set controller.
 assumes: inputs synchronous-capable levels, one 250 MHz clock, classic wishbone master.
*/
// Function
// (R1) mains-breaker close input acts only in hand-operation or test mode
// (R2) with no open input assigned, close input toggles the breaker
// (R3) mains-breaker open input acts only in hand-operation or test mode
// (R4) external-control input suppresses faults about breaker state while active
// (R5) sync request input makes the device synchronize for outside equipment
// (R6) fault reset rising edge clears all faults
// (R7) acknowledge rising edge acknowledges faults and silences horn
// (R8) unloaded-test edge in unattended mode starts a test without load
// (R9) loaded-test edge in unattended mode starts a test with load
// (R10) pulse test lasts the duration setting; zero means never run
// (R11) second edge on the same test input stops its test
// (R12) test level moves unattended to test unless intervention needed; release returns
// (R13) level-driven test uses the test-load enable setting
// (R14) remote-run level moves unattended to remote-run; release returns
// (R15) manual start edge in hand mode makes one start attempt until done
// (R16) manual stop edge in hand mode commands engine stop
// (R17) per-input polarity bit, reset to zero
// (R18) per-input delay setting, used by delayed functions only
// (R19) inputs synchronized, edges give one-cycle activation pulses
// (R20) mode held in one encoded register, reset to idle-clear
`timescale 1ns/1ps
`include "input_cmd_cfg.svh"
module input_cmd #(
    parameter int TICK_CYC = `TICK_PERIOD_NS / `CLK_PERIOD_NS
) (
    input  wire logic                    i_core_clk,
    input  wire logic                    i_rstn,
    input  wire logic [`N_IN-1:0]        i_din,
    input  wire logic                    i_mb_closed,
    input  wire logic                    i_auto_req,
    input  wire logic                    i_start_done,
    input  wire input_cmd_pkg::wb_req_t  i_wb,
    output logic                         o_wb_ack,
    output logic [31:0]                  o_wb_dat,
    output input_cmd_pkg::mode_t         o_mode,
    output logic                         o_mb_close,
    output logic                         o_mb_open,
    output logic                         o_mb_ext,
    output logic                         o_sync_req,
    output logic                         o_fault_reset,
    output logic                         o_fault_ack,
    output logic                         o_horn_silence,
    output logic                         o_test_run,
    output logic                         o_test_load,
    output logic                         o_start_cmd,
    output logic                         o_stop_cmd
);
    input_cmd_pkg::state_t q;
    input_cmd_pkg::state_t d;
    logic [`N_IN-1:0]      lvl;
    logic [`N_IN-1:0]      rise;
    logic                  wr;
    logic                  hand_or_test;
    logic [31:0]           wm;
    logic [31:0]           cur;
    logic [31:0]           nw;

    function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] s);
        logic [31:0] r;
        r = o;
        for (int b = 0; b < 4; b++) begin
            if (s[b]) begin
                r[b*8 +: 8] = n[b*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    assign lvl  = q.s2 ^ q.pol;             // (R17)
    assign rise = lvl & ~q.prev;            // (R19)
    assign wr   = i_wb.cyc && i_wb.stb && i_wb.we && !q.ack;
    assign hand_or_test = (q.mode == input_cmd_pkg::MODE_HAND) || (q.mode == input_cmd_pkg::MODE_TEST);

    always_comb begin
        d = q;
        cur = 32'h0000_0000;
        wm = 32'h0000_0000;
        nw = 32'h0000_0000;
        d.s1   = i_din;                     // (R19)
        d.s2   = q.s1;
        d.prev = lvl;
        // one-millisecond tick; slow timers step on it to keep counters narrow
        d.tick = 1'b0;
        if (q.pcnt == 18'(TICK_CYC - 1)) begin
            d.pcnt = 18'h0_0000;
            d.tick = 1'b1;
        end else begin
            d.pcnt = q.pcnt + 18'h0_0001;
        end
        d.mb_close = 1'b0;
        d.mb_open  = 1'b0;
        d.frst     = 1'b0;
        d.fack     = 1'b0;
        d.stop     = 1'b0;
        if (rise[`IN_MB_CLOSE] && hand_or_test) begin                  // (R1)
            if (!q.open_asg && i_mb_closed) begin
                d.mb_open = 1'b1;                                       // (R2)
            end else begin
                d.mb_close = 1'b1;
            end
        end
        if (rise[`IN_MB_OPEN] && hand_or_test && q.open_asg) begin     // (R3)
            d.mb_open = 1'b1;
        end
        d.mb_ext = lvl[`IN_MB_EXT];                                     // (R4)
        d.sync   = lvl[`IN_MB_SYNC];                                    // (R5)
        d.frst   = rise[`IN_FLT_RST];                                   // (R6)
        d.fack   = rise[`IN_FLT_ACK];                                   // (R7)
        // remote-run qualified by its own delay; release drops at once
        if (!lvl[`IN_RRUN]) begin                                       // (R18)
            d.dcnt = 8'h00;
            d.rr   = 1'b0;
        end else if (q.dcnt >= q.dly[`IN_RRUN]) begin
            d.rr = 1'b1;
        end else if (q.tick) begin
            d.dcnt = q.dcnt + 8'h01;
        end
        // pulse tests
        if (q.tst_run) begin
            if ((q.tst_src && rise[`IN_TST_LD]) || (!q.tst_src && rise[`IN_TST_UNL])) begin
                d.tst_run = 1'b0;                                       // (R11)
            end else if (q.tcnt >= q.tdur) begin
                d.tst_run = 1'b0;                                       // (R10)
            end else if (q.tick) begin
                d.tcnt = q.tcnt + 16'h0001;
            end
        end else if (q.mode == input_cmd_pkg::MODE_UNATTENDED && q.tdur != 16'h0000) begin   // (R10)
            if (rise[`IN_TST_UNL]) begin                                // (R8)
                d.tst_run  = 1'b1;
                d.tst_load = 1'b0;
                d.tst_src  = 1'b0;
                d.tcnt     = 16'h0000;
            end else if (rise[`IN_TST_LD]) begin                        // (R9)
                d.tst_run  = 1'b1;
                d.tst_load = 1'b1;
                d.tst_src  = 1'b1;
                d.tcnt     = 16'h0000;
            end
        end
        // mode changes; a software write wins over the inputs
        if (wr && i_wb.adr == `ADR_CTRL && i_wb.sel[0]
            && i_wb.dat[2:0] <= 3'(input_cmd_pkg::MODE_UNATTENDED)) begin
            d.mode = input_cmd_pkg::mode_t'(i_wb.dat[2:0]);            // (R20)
        end else begin
            unique case (q.mode)
                input_cmd_pkg::MODE_UNATTENDED: begin
                    if (lvl[`IN_TST_LVL] && !i_auto_req && !q.tst_run) begin
                        d.mode = input_cmd_pkg::MODE_TEST;              // (R12)
                    end else if (q.rr) begin
                        d.mode = input_cmd_pkg::MODE_REMOTE_RUN;        // (R14)
                    end
                end
                input_cmd_pkg::MODE_TEST: begin
                    if (!lvl[`IN_TST_LVL]) begin
                        d.mode = input_cmd_pkg::MODE_UNATTENDED;        // (R12)
                    end
                end
                input_cmd_pkg::MODE_REMOTE_RUN: begin
                    if (!q.rr) begin
                        d.mode = input_cmd_pkg::MODE_UNATTENDED;        // (R14)
                    end
                end
                default: begin
                end
            endcase
        end
        d.test_load_out = d.tst_run ? d.tst_load
                        : (d.mode == input_cmd_pkg::MODE_TEST) && q.tload_en;   // (R13)
        // start held until the sequencer reports success or failure
        if (q.start && i_start_done) begin
            d.start = 1'b0;
        end else if (rise[`IN_MSTART] && q.mode == input_cmd_pkg::MODE_HAND) begin
            d.start = 1'b1;                                             // (R15)
        end
        d.stop = rise[`IN_MSTOP] && q.mode == input_cmd_pkg::MODE_HAND; // (R16)
        // wishbone slave: one wait state, unmapped reads zero, writes dropped
        d.ack = i_wb.cyc && i_wb.stb && !q.ack;
        unique case (i_wb.adr)
            `ADR_CTRL: cur = {22'h00_0000, q.open_asg, q.tload_en, 5'h00, 3'(q.mode)};
            `ADR_POL:  cur = {20'h0_0000, q.pol};
            `ADR_TDUR: cur = {16'h0000, q.tdur};
            `ADR_STAT: cur = {12'h000, q.start, q.rr, q.test_load_out, q.tst_run, 4'h0, lvl};
            default: begin
                if (i_wb.adr >= `ADR_DLY0 && i_wb.adr < 8'(`ADR_DLY0 + 4 * `N_IN)
                    && i_wb.adr[1:0] == 2'b00) begin
                    cur = {24'h00_0000, q.dly[4'((i_wb.adr - `ADR_DLY0) >> 2)]};
                end
            end
        endcase
        d.rdat = cur;
        if (wr) begin
            nw = merge(cur, i_wb.dat, i_wb.sel);
            wm = nw;
            unique case (i_wb.adr)
                `ADR_CTRL: begin
                    d.tload_en = wm[`CTRL_TLOAD_BIT];
                    d.open_asg = wm[`CTRL_OPEN_BIT];
                end
                `ADR_POL:  d.pol  = wm[`N_IN-1:0];                      // (R17)
                `ADR_TDUR: d.tdur = wm[15:0];
                default: begin
                    if (i_wb.adr >= `ADR_DLY0 && i_wb.adr < 8'(`ADR_DLY0 + 4 * `N_IN)
                        && i_wb.adr[1:0] == 2'b00) begin
                        d.dly[4'((i_wb.adr - `ADR_DLY0) >> 2)] = wm[7:0];   // (R18)
                    end
                end
            endcase
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            q <= '0;
            q.mode <= input_cmd_pkg::MODE_IDLE_CLEAR;                   // (R20)
            q.pol  <= `POL_RST;                                         // (R17)
            q.tdur <= `TDUR_RST;
            q.dly  <= {`N_IN{`DLY_RST}};
        end else begin
            q <= d;
        end
    end

    assign o_wb_ack       = q.ack;
    assign o_wb_dat       = q.rdat;
    assign o_mode         = q.mode;
    assign o_mb_close     = q.mb_close;
    assign o_mb_open      = q.mb_open;
    assign o_mb_ext       = q.mb_ext;
    assign o_sync_req     = q.sync;
    assign o_fault_reset  = q.frst;
    assign o_fault_ack    = q.fack;
    assign o_horn_silence = q.fack;
    assign o_test_run     = q.tst_run;
    assign o_test_load    = q.test_load_out;
    assign o_start_cmd    = q.start;
    assign o_stop_cmd     = q.stop;

    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_rstn);

    AST_CLOSE_MODE: assert property (o_mb_close |-> $past(hand_or_test)) // (R1)
        else $error("close outside hand or test mode");
    AST_TOGGLE: assert property (rise[`IN_MB_CLOSE] && hand_or_test && !q.open_asg && i_mb_closed // (R2)
        |=> o_mb_open && !o_mb_close)
        else $error("toggle did not open");
    AST_OPEN: assert property (rise[`IN_MB_OPEN] && hand_or_test && q.open_asg |=> o_mb_open) // (R3)
        else $error("open command lost");
    AST_EXT: assert property (lvl[`IN_MB_EXT] |=> o_mb_ext) // (R4)
        else $error("external control not shown");
    AST_SYNC: assert property ($rose(lvl[`IN_MB_SYNC]) |=> o_sync_req) // (R5)
        else $error("sync request not shown");
    AST_FRST: assert property (rise[`IN_FLT_RST] |=> o_fault_reset ##1 !o_fault_reset) // (R6)
        else $error("fault reset pulse wrong");
    AST_ACK: assert property (rise[`IN_FLT_ACK] |=> o_fault_ack && o_horn_silence) // (R7)
        else $error("acknowledge missing");
    AST_TST_UNL: assert property (rise[`IN_TST_UNL] && !q.tst_run && q.tdur != 16'h0000 // (R8)
        && q.mode == input_cmd_pkg::MODE_UNATTENDED |=> o_test_run && !q.tst_load)
        else $error("unloaded test not started");
    AST_TST_LD: assert property (rise[`IN_TST_LD] && !q.tst_run && q.tdur != 16'h0000 // (R9)
        && q.mode == input_cmd_pkg::MODE_UNATTENDED |=> o_test_run && o_test_load)
        else $error("loaded test not started");
    AST_TST_ZERO: assert property (!q.tst_run && q.tdur == 16'h0000 |=> !o_test_run) // (R10)
        else $error("test ran with zero duration");
    AST_TST_STOP: assert property (q.tst_run && (q.tst_src ? rise[`IN_TST_LD] : rise[`IN_TST_UNL]) // (R11)
        |=> !o_test_run)
        else $error("second edge did not stop test");
    AST_TST_LVL: assert property (q.mode == input_cmd_pkg::MODE_TEST && !lvl[`IN_TST_LVL] && !wr // (R12)
        |=> o_mode == input_cmd_pkg::MODE_UNATTENDED)
        else $error("test mode not released");
    AST_RRUN: assert property (q.mode == input_cmd_pkg::MODE_UNATTENDED && q.rr && !wr // (R14)
        && !lvl[`IN_TST_LVL] |=> o_mode == input_cmd_pkg::MODE_REMOTE_RUN)
        else $error("remote-run not entered");
    AST_START: assert property (rise[`IN_MSTART] && q.mode == input_cmd_pkg::MODE_HAND // (R15)
        |=> o_start_cmd)
        else $error("start attempt missing");
    AST_START_HOLD: assert property (o_start_cmd && !i_start_done |=> o_start_cmd) // (R15)
        else $error("start attempt dropped before it ended");
    AST_STOP: assert property (rise[`IN_MSTOP] && q.mode == input_cmd_pkg::MODE_HAND // (R16)
        |=> o_stop_cmd ##1 !o_stop_cmd)
        else $error("stop pulse wrong");
    // load flag of a level test is registered, so it follows the enable one cycle late
    AST_TLOAD_LVL: assert property (o_mode == input_cmd_pkg::MODE_TEST && !o_test_run // (R13)
        |-> o_test_load == $past(q.tload_en))
        else $error("level test load does not follow enable");
    // delay check assumes software leaves the delay setting alone while the input is held
    AST_RRUN_DLY: assert property ($rose(q.rr) |-> q.dcnt >= q.dly[`IN_RRUN]) // (R18)
        else $error("remote-run qualified before its delay");
    AST_RRUN_OFF: assert property (!lvl[`IN_RRUN] |=> !q.rr) // (R14)
        else $error("remote-run qualification held after release");
    AST_WB: assert property (i_wb.cyc && i_wb.stb && !o_wb_ack |=> o_wb_ack ##1 !o_wb_ack)
        else $error("bus ack timing wrong");

    COV_TEST: cover property (o_test_run ##[1:20] !o_test_run);
    COV_RRUN: cover property (o_mode == input_cmd_pkg::MODE_REMOTE_RUN);
    COV_TOGGLE: cover property (o_mb_open && !q.open_asg);
    COV_START: cover property (o_start_cmd ##[1:20] !o_start_cmd);
endmodule : input_cmd

// ### bench/input_switches.sv
/*
 far-side model: switches, pushbuttons, mains breaker contact and engine start sequencer.
 assumes the bench drives logical levels and terminal polarity; one clock, active-low async reset.
*/
`timescale 1ns/1ps
module input_switches #(
    parameter int START_CYC = 5
) (
    input  wire logic        i_core_clk,
    input  wire logic        i_rstn,
    input  wire logic [11:0] i_act,
    input  wire logic [11:0] i_pol,
    input  wire logic        i_start_cmd,
    input  wire logic        i_mb_close,
    input  wire logic        i_mb_open,
    output logic [11:0]      o_din,
    output logic             o_mb_closed,
    output logic             o_start_done
);
    logic [7:0] cnt_q;
    // a terminal tied to negative reads 1; inverted polarity means open is active
    assign o_din = i_act ^ i_pol;
    // breaker contact follows the commands so the toggle sees a real status
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_mb_closed <= 1'b0;
            cnt_q       <= 8'h00;
        end else begin
            if (i_mb_close) o_mb_closed <= 1'b1;
            else if (i_mb_open) o_mb_closed <= 1'b0;
            cnt_q <= !i_start_cmd ? 8'h00 : (cnt_q == 8'(START_CYC)) ? cnt_q : cnt_q + 8'h01;
        end
    end
    // start attempt ends after a fixed crank time, success or failure alike
    assign o_start_done = i_start_cmd && (cnt_q == 8'(START_CYC));
endmodule : input_switches

// ### bench/input_command_mode_logic_tb.sv
/*
 self-checking bench for the input command interpreter.
 assumes the switch model in input_switches.sv and a shortened tick of 4 cycles.
*/
`timescale 1ns/1ps
`include "input_cmd_cfg.svh"
module input_command_mode_logic_tb;
    logic                   core_clk = 1'b0;
    logic                   rstn     = 1'b0;
    logic                   auto_req = 1'b0;
    logic [`N_IN-1:0]       act      = '0;
    logic [`N_IN-1:0]       pol      = '0;
    logic [`N_IN-1:0]       din;
    logic                   mb_closed, start_done, wb_ack;
    logic [31:0]            wb_dat;
    input_cmd_pkg::wb_req_t wb = '0;
    input_cmd_pkg::mode_t   mode;
    logic                   mb_close, mb_open, mb_ext, sync_req, frst, fack, horn, test_run, test_load, start, stop;
    int                     error_cnt = 0;
    int                     samples_checked = 0;
    int                     pc [6] = '{default: 0};
    wire  [5:0]             pv = {stop, horn, fack, frst, mb_open, mb_close};

    always #2 core_clk = ~core_clk;
    always @(posedge core_clk) for (int k = 0; k < 6; k++) pc[k] <= pc[k] + int'(pv[k]);

    input_switches #(.START_CYC(5)) sw_u (.i_core_clk(core_clk), .i_rstn(rstn), .i_act(act), .i_pol(pol),
        .i_start_cmd(start), .i_mb_close(mb_close), .i_mb_open(mb_open), .o_din(din),
        .o_mb_closed(mb_closed), .o_start_done(start_done));

    input_cmd #(.TICK_CYC(4)) dut_u (.i_core_clk(core_clk), .i_rstn(rstn), .i_din(din), .i_mb_closed(mb_closed),
        .i_auto_req(auto_req), .i_start_done(start_done), .i_wb(wb), .o_wb_ack(wb_ack), .o_wb_dat(wb_dat),
        .o_mode(mode), .o_mb_close(mb_close), .o_mb_open(mb_open), .o_mb_ext(mb_ext), .o_sync_req(sync_req),
        .o_fault_reset(frst), .o_fault_ack(fack), .o_horn_silence(horn), .o_test_run(test_run),
        .o_test_load(test_load), .o_start_cmd(start), .o_stop_cmd(stop));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic chk_mode(input input_cmd_pkg::mode_t exp);
        chk({29'h0, mode}, {29'h0, exp});
    endtask : chk_mode
    // outputs are read pre-edge at the sampling edge, so ack and data come from the same cycle
    task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] wd, output logic [31:0] rd);
        @(posedge core_clk);
        wb <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hF, dat: wd};
        do @(posedge core_clk); while (wb_ack !== 1'b1);
        rd = wb_dat;
        wb <= '0;
    endtask : wb_xfer
    task automatic wr(input logic [7:0] adr, input logic [31:0] d);
        logic [31:0] x;
        wb_xfer(1'b1, adr, d, x);
    endtask : wr
    task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp);
        logic [31:0] x;
        wb_xfer(1'b0, adr, 32'h0, x);
        chk(x, exp);
    endtask : rd_chk
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask : cyc
    task automatic lvl(input int idx, input logic v, input int n);
        @(posedge core_clk);
        act[idx] <= v;
        cyc(n);
    endtask : lvl
    // a held press must still give exactly one pulse on each expected output
    task automatic press(input int idx, input logic [5:0] exp);
        int base [6];
        base = pc;
        lvl(idx, 1'b1, 8);
        lvl(idx, 1'b0, 6);
        for (int k = 0; k < 6; k++) chk(32'(pc[k] - base[k]), {31'h0, exp[k]});
    endtask : press
    task automatic results;
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : results

    initial begin
        cyc(20000);
        error_cnt++;
        results();
    end

    initial begin
        cyc(2);
        rstn <= 1'b1;
        chk_mode(input_cmd_pkg::MODE_IDLE_CLEAR);
        rd_chk(`ADR_POL, {20'h0, `POL_RST});
        rd_chk(`ADR_TDUR, {16'h0, `TDUR_RST});
        rd_chk(`ADR_DLY0, {24'h0, `DLY_RST});
        wr(8'h80, 32'hFFFF_FFFF);
        rd_chk(8'h80, 32'h0);
        wr(`ADR_CTRL, 32'h0000_0005);
        rd_chk(`ADR_CTRL, 32'h0);
        $display("test reset done");
        press(`IN_MB_CLOSE, 6'b000000);
        wr(`ADR_CTRL, 32'h0000_0001);
        chk_mode(input_cmd_pkg::MODE_HAND);
        press(`IN_MB_CLOSE, 6'b000001);
        press(`IN_MB_CLOSE, 6'b000010);
        wr(`ADR_CTRL, 32'h0000_0201);
        press(`IN_MB_CLOSE, 6'b000001);
        press(`IN_MB_OPEN, 6'b000010);
        wr(`ADR_CTRL, 32'h0000_0202);
        press(`IN_MB_OPEN, 6'b000000);
        $display("test breaker done");
        press(`IN_FLT_RST, 6'b000100);
        press(`IN_FLT_ACK, 6'b011000);
        lvl(`IN_MB_EXT, 1'b1, 0);
        lvl(`IN_MB_SYNC, 1'b1, 6);
        chk({30'h0, mb_ext, sync_req}, 32'h3);
        rd_chk(`ADR_STAT, 32'h0000_000C);
        lvl(`IN_MB_EXT, 1'b0, 0);
        lvl(`IN_MB_SYNC, 1'b0, 6);
        chk({30'h0, mb_ext, sync_req}, 32'h0);
        $display("test faults and levels done");
        wr(`ADR_POL, 32'h0000_0020);
        cyc(8);
        chk(32'(pc[3]), 32'h2);
        rd_chk(`ADR_POL, 32'h0000_0020);
        wr(`ADR_POL, 32'h0);
        $display("test polarity done");
        wr(`ADR_CTRL, 32'h0000_0001);
        lvl(`IN_MSTART, 1'b1, 5);
        chk({31'h0, start}, 32'h1);
        lvl(`IN_MSTART, 1'b0, 12);
        chk({31'h0, start}, 32'h0);
        press(`IN_MSTOP, 6'b100000);
        wr(`ADR_CTRL, 32'h0000_0002);
        lvl(`IN_MSTART, 1'b1, 6);
        chk({31'h0, start}, 32'h0);
        lvl(`IN_MSTART, 1'b0, 4);
        press(`IN_MSTOP, 6'b000000);
        $display("test start stop done");
        lvl(`IN_TST_UNL, 1'b1, 6);
        chk({31'h0, test_run}, 32'h0);
        lvl(`IN_TST_UNL, 1'b0, 4);
        wr(`ADR_TDUR, 32'h0000_0002);
        lvl(`IN_TST_UNL, 1'b1, 5);
        chk({30'h0, test_run, test_load}, 32'h2);
        lvl(`IN_TST_UNL, 1'b0, 30);
        chk({31'h0, test_run}, 32'h0);
        wr(`ADR_TDUR, 32'h0000_0064);
        lvl(`IN_TST_LD, 1'b1, 5);
        chk({30'h0, test_run, test_load}, 32'h3);
        lvl(`IN_TST_LD, 1'b0, 4);
        lvl(`IN_TST_LD, 1'b1, 6);
        chk({31'h0, test_run}, 32'h0);
        lvl(`IN_TST_LD, 1'b0, 4);
        $display("test pulse tests done");
        wr(`ADR_CTRL, 32'h0000_0102);
        lvl(`IN_TST_LVL, 1'b1, 6);
        chk_mode(input_cmd_pkg::MODE_TEST);
        chk({31'h0, test_load}, 32'h1);
        lvl(`IN_TST_LVL, 1'b0, 6);
        chk_mode(input_cmd_pkg::MODE_UNATTENDED);
        auto_req <= 1'b1;
        lvl(`IN_TST_LVL, 1'b1, 6);
        chk_mode(input_cmd_pkg::MODE_UNATTENDED);
        lvl(`IN_TST_LVL, 1'b0, 2);
        auto_req <= 1'b0;
        wr(`ADR_CTRL, 32'h0000_0002);
        lvl(`IN_TST_LVL, 1'b1, 6);
        chk_mode(input_cmd_pkg::MODE_TEST);
        chk({31'h0, test_load}, 32'h0);
        lvl(`IN_TST_LVL, 1'b0, 6);
        $display("test level test done");
        wr(`ADR_DLY0 + 8'h24, 32'h0000_0003);
        lvl(`IN_RRUN, 1'b1, 6);
        chk_mode(input_cmd_pkg::MODE_UNATTENDED);
        cyc(20);
        chk_mode(input_cmd_pkg::MODE_REMOTE_RUN);
        lvl(`IN_RRUN, 1'b0, 6);
        chk_mode(input_cmd_pkg::MODE_UNATTENDED);
        wr(`ADR_CTRL, 32'h0000_0001);
        lvl(`IN_RRUN, 1'b1, 26);
        chk_mode(input_cmd_pkg::MODE_HAND);
        lvl(`IN_TST_LVL, 1'b1, 6);
        chk_mode(input_cmd_pkg::MODE_HAND);
        $display("test remote run done");
        rstn <= 1'b0;
        cyc(2);
        rstn <= 1'b1;
        chk_mode(input_cmd_pkg::MODE_IDLE_CLEAR);
        rd_chk(`ADR_CTRL, 32'h0);
        rd_chk(`ADR_TDUR, {16'h0, `TDUR_RST});
        rd_chk(`ADR_DLY0 + 8'h24, {24'h0, `DLY_RST});
        $display("test second reset done");
        results();
    end
endmodule : input_command_mode_logic_tb
